//--- common/psm_pkg.sv
// pin state controller package: constants, enums, structs, helpers
// assumes a 32-bit avalon-mm bus and four controlled pins
// How it works
// - isolated: hi-z, pull off, input forced 0
// - input open: hi-z, pull off, input passes
// - input pull: hi-z, pull from pull register
// - clock input: input gated while oscillator stopped
// - oscillator stopped halts oscillator, pin hi-z
// - usb owned by controller, disabled means hi-z
// - register controlled: registers (peripheral inputs for peripheral function) drive output, pull
// - controlled no pull: registers drive, pull off
// - hold input: latched drive, input open
// - hold isolated: latched drive, input gated
// - snapshot: copied gpio drive, input gated
// - two reset states: power-on and external
// - standby level bit picks status column
// - deep standby status kept while hold set
// - reset pin: input, pull on, always
// - boot pin: input, no pull, always
// - debug wire in init (external reset) sets pull bit, not in power-on
// - analog function: hi-z, pull off, input 0
// - oscillator function: hi-z, pull off, input 0
// - usb function: hi-z, input forced 0
// - interrupt pin column statuses per mode
// - peripheral pin column statuses per mode
package psm_pkg;
	localparam int PSM_NPIN = 4;
	localparam int PSM_AW = 8;
	localparam int PSM_FW = 4;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FUNC = 8'h04;
	localparam logic [7:0] ADDR_GPIO = 8'h08;
	localparam logic [7:0] ADDR_PULL = 8'h0C;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	// field positions
	localparam int CTRL_LVL_BIT = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam int GPIO_OE_LSB = 8;
	localparam int STAT_PU_LSB = 4;
	localparam int STAT_DIN_LSB = 8;
	localparam int STAT_COL_LSB = 16;
	localparam int STAT_RET_BIT = 20;
	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [15:0] FUNC_RST = 16'h0000;
	localparam logic [3:0] GPIO_RST = 4'h0;
	localparam logic [3:0] PULL_RST = 4'h0;

	typedef enum logic [2:0] {CPU_POR, CPU_INIT, CPU_RUN, CPU_STBY, CPU_DEEP} psm_cpu_e;
	typedef enum logic [2:0] {COL_POR, COL_INIT, COL_RUN, COL_SBY_L0, COL_SBY_L1,
		COL_DS_L0, COL_DS_L1, COL_DS_RET} psm_col_e;
	typedef enum logic [3:0] {FN_GPIO, FN_GPIO_NP, FN_OSC, FN_CLKIN, FN_ANALOG, FN_USB,
		FN_EXTINT, FN_PERIPH, FN_DBGWIRE, FN_RSTIN, FN_BOOTIN} psm_fn_e;
	typedef enum logic [3:0] {isolated_status, input_open_status, input_pull_status,
		osc_gated_input_status, osc_stopped_status, osc_running_status, usb_owned_status,
		usb_disabled_status, reg_controlled_status, controlled_nopull_status,
		hold_input_status, hold_isolated_status, gpio_snapshot_status, rst_in_status,
		boot_in_status} psm_stat_e;
	typedef struct packed {
		logic [PSM_NPIN-1:0] out;
		logic [PSM_NPIN-1:0] oe;
		logic [PSM_NPIN-1:0] pu;
	} psm_pad_s;

	function automatic logic [31:0] psm_be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
			begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : psm_be_merge
endpackage : psm_pkg

//--- rtl/psm_status_lut.sv
// status lookup: pin status from selected function and status column
// assumes column already resolved from cpu state and standby controls
`timescale 1ns/1ps
module psm_status_lut
	import psm_pkg::*;
(
	input wire psm_fn_e fn_i,
	input wire psm_col_e col_i,
	output psm_stat_e stat_o
);
	localparam psm_stat_e S_IS = isolated_status;
	localparam psm_stat_e S_IP = input_pull_status;
	localparam psm_stat_e S_PC = reg_controlled_status;
	localparam psm_stat_e S_HC = hold_input_status;
	localparam psm_stat_e S_HS = hold_isolated_status;
	localparam psm_stat_e S_GS = gpio_snapshot_status;
	localparam psm_stat_e S_OS = osc_stopped_status;
	localparam psm_stat_e S_OE = osc_running_status;
	localparam psm_stat_e S_US = usb_disabled_status;

	psm_stat_e row [8];

	// ========================================
	// column rows per function
	always_comb
	begin
		row = '{default: S_IS};
		unique case (fn_i)
			FN_GPIO: row = '{S_IS, input_open_status, S_PC, S_HC, S_IS, S_HS, S_IS, S_HS};
			FN_GPIO_NP: row = '{S_IS, input_open_status, controlled_nopull_status, S_HC,
				S_IS, S_HS, S_IS, S_HS};
			FN_OSC: row = '{S_OS, S_OS, S_OE, S_OE, S_OE, S_OS, S_OS, S_OS};
			FN_CLKIN: row = '{S_IS, S_IS, osc_gated_input_status, osc_gated_input_status,
				osc_gated_input_status, S_IS, S_IS, S_IS};
			FN_ANALOG: row = '{default: S_IS};
			FN_USB: row = '{S_IS, S_IS, usb_owned_status, S_US, S_US, S_US, S_US, S_US};
			FN_EXTINT: row = '{S_IS, S_IS, S_IP, S_IP, S_IP, S_GS, S_IS, S_GS};
			FN_PERIPH: row = '{S_IS, S_IS, S_PC, S_HC, S_IS, S_GS, S_IS, S_GS};
			FN_DBGWIRE: row = '{S_IS, S_IP, S_PC, S_IP, S_IP, S_IP, S_IP, S_IP};
			FN_RSTIN: row = '{default: rst_in_status};
			FN_BOOTIN: row = '{default: boot_in_status};
			default: row = '{default: S_IS};
		endcase
		stat_o = row[col_i];
	end
endmodule : psm_status_lut

//--- rtl/psm_pin_ctrl.sv
// pin state controller: pad controls per pin from function, cpu state, standby bits
// assumes an avalon-mm master on clk_i and a sequencer giving the cpu state
`timescale 1ns/1ps
module psm_pin_ctrl
	import psm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [PSM_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire psm_cpu_e cpu_state_i,
	input wire logic [PSM_NPIN-1:0] osc_running_i,
	input wire logic [PSM_NPIN-1:0] pad_in_i,
	input wire psm_pad_s periph_i,
	output psm_pad_s pad_o,
	output logic [PSM_NPIN-1:0] din_o,
	output logic [PSM_NPIN-1:0] osc_en_o,
	output logic [PSM_NPIN-1:0] usb_own_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic ack_q;
	logic [31:0] rdata_q;
	logic [1:0] ctrl_q;
	logic [15:0] func_q;
	logic [PSM_NPIN-1:0] gpio_out_q;
	logic [PSM_NPIN-1:0] gpio_oe_q;
	logic [PSM_NPIN-1:0] pcr_q;
	logic ret_q;
	logic stby_q;
	psm_pad_s pad_q;
	psm_pad_s pad_d;
	psm_pad_s hold_q;
	psm_pad_s snap_q;
	psm_pad_s hold_src;
	psm_pad_s snap_src;
	logic [PSM_NPIN-1:0] din_q;
	logic [PSM_NPIN-1:0] din_d;
	logic [PSM_NPIN-1:0] osc_en_q;
	logic [PSM_NPIN-1:0] osc_en_d;
	logic [PSM_NPIN-1:0] usb_q;
	logic [PSM_NPIN-1:0] usb_d;
	logic req;
	logic wr_en;
	logic stby;
	logic entry;
	logic [31:0] wr_word;
	logic [31:0] rd_word;
	psm_col_e col;
	psm_fn_e fn [PSM_NPIN];
	psm_stat_e stat [PSM_NPIN];

	// ========================================
	// avalon slave handshake
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_q;
	assign wr_en = avs_write_i & ack_q;
	assign avs_readdata_o = rdata_q;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ack_q <= 1'b0;
		end
		else
		begin
			ack_q <= req & ~ack_q;
		end
	end

	always_comb
	begin
		rd_word = 32'h0000_0000;
		unique case (avs_address_i)
			ADDR_CTRL: rd_word[1:0] = ctrl_q;
			ADDR_FUNC: rd_word[15:0] = func_q;
			ADDR_GPIO:
			begin
				rd_word[PSM_NPIN-1:0] = gpio_out_q;
				rd_word[GPIO_OE_LSB +: PSM_NPIN] = gpio_oe_q;
			end
			ADDR_PULL: rd_word[PSM_NPIN-1:0] = pcr_q;
			ADDR_STAT:
			begin
				rd_word[PSM_NPIN-1:0] = pad_q.oe;
				rd_word[STAT_PU_LSB +: PSM_NPIN] = pad_q.pu;
				rd_word[STAT_DIN_LSB +: PSM_NPIN] = din_q;
				rd_word[STAT_COL_LSB +: 3] = col;
				rd_word[STAT_RET_BIT] = ret_q;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rdata_q <= 32'h0000_0000;
		end
		else if (avs_read_i & ~ack_q)
		begin
			rdata_q <= rd_word;
		end
	end

	always_comb
	begin
		wr_word = 32'h0000_0000;
		unique case (avs_address_i)
			ADDR_CTRL: wr_word[1:0] = ctrl_q;
			ADDR_FUNC: wr_word[15:0] = func_q;
			ADDR_GPIO:
			begin
				wr_word[PSM_NPIN-1:0] = gpio_out_q;
				wr_word[GPIO_OE_LSB +: PSM_NPIN] = gpio_oe_q;
			end
			ADDR_PULL: wr_word[PSM_NPIN-1:0] = pcr_q;
			default: wr_word = 32'h0000_0000;
		endcase
		wr_word = psm_be_merge(wr_word, avs_writedata_i, avs_byteenable_i);
	end

	// ========================================
	// software registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_q <= CTRL_RST;
			func_q <= FUNC_RST;
			gpio_out_q <= GPIO_RST;
			gpio_oe_q <= GPIO_RST;
		end
		else if (wr_en)
		begin
			if (avs_address_i == ADDR_CTRL)
			begin
				ctrl_q <= wr_word[1:0];
			end
			if (avs_address_i == ADDR_FUNC)
			begin
				func_q <= wr_word[15:0];
			end
			if (avs_address_i == ADDR_GPIO)
			begin
				gpio_out_q <= wr_word[PSM_NPIN-1:0];
				gpio_oe_q <= wr_word[GPIO_OE_LSB +: PSM_NPIN];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pcr_q <= PULL_RST;
		end
		else
		begin
			if (wr_en && avs_address_i == ADDR_PULL)
			begin
				pcr_q <= wr_word[PSM_NPIN-1:0];
			end
			for (int i = 0; i < PSM_NPIN; i++)
			begin
				if (cpu_state_i == CPU_INIT && fn[i] == FN_DBGWIRE)
				begin
					pcr_q[i] <= 1'b1;
				end
			end
		end
	end

	// ========================================
	// status column
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ret_q <= 1'b0;
		end
		else if (cpu_state_i == CPU_DEEP)
		begin
			ret_q <= 1'b1;
		end
		else if (!ctrl_q[CTRL_HOLD_BIT] || cpu_state_i != CPU_RUN)
		begin
			ret_q <= 1'b0;
		end
	end

	always_comb
	begin
		unique case (cpu_state_i)
			CPU_POR: col = COL_POR;
			CPU_INIT: col = COL_INIT;
			CPU_RUN: col = (ret_q && ctrl_q[CTRL_HOLD_BIT]) ? COL_DS_RET : COL_RUN;
			CPU_STBY: col = ctrl_q[CTRL_LVL_BIT] ? COL_SBY_L1 : COL_SBY_L0;
			CPU_DEEP: col = ctrl_q[CTRL_LVL_BIT] ? COL_DS_L1 : COL_DS_L0;
			default: col = COL_POR;
		endcase
	end

	for (genvar g = 0; g < PSM_NPIN; g++)
	begin : g_lut
		assign fn[g] = psm_fn_e'(func_q[g*PSM_FW +: PSM_FW]);
		psm_status_lut u_lut (
			.fn_i(fn[g]),
			.col_i(col),
			.stat_o(stat[g])
		);
	end

	// ========================================
	// standby entry capture
	assign stby = (cpu_state_i == CPU_STBY) || (cpu_state_i == CPU_DEEP);
	assign entry = stby & ~stby_q;
	assign hold_src = entry ? pad_q : hold_q;
	assign snap_src = entry ? psm_pad_s'({gpio_out_q, gpio_oe_q, pcr_q}) : snap_q;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			stby_q <= 1'b0;
			hold_q <= '0;
			snap_q <= '0;
		end
		else
		begin
			stby_q <= stby;
			hold_q <= hold_src;
			snap_q <= snap_src;
		end
	end

	// ========================================
	// pad control decode
	always_comb
	begin
		pad_d = '0;
		din_d = '0;
		osc_en_d = '0;
		usb_d = '0;
		for (int i = 0; i < PSM_NPIN; i++)
		begin
			unique case (stat[i])
				isolated_status: din_d[i] = 1'b0;
				input_open_status: din_d[i] = pad_in_i[i];
				input_pull_status:
				begin
					pad_d.pu[i] = pcr_q[i];
					din_d[i] = pad_in_i[i];
				end
				osc_gated_input_status: din_d[i] = pad_in_i[i] & osc_running_i[i];
				osc_stopped_status: osc_en_d[i] = 1'b0;
				osc_running_status: osc_en_d[i] = 1'b1;
				usb_owned_status: usb_d[i] = 1'b1;
				usb_disabled_status: usb_d[i] = 1'b0;
				reg_controlled_status:
				begin
					pad_d.out[i] = fn[i] == FN_PERIPH ? periph_i.out[i] : gpio_out_q[i];
					pad_d.oe[i] = fn[i] == FN_PERIPH ? periph_i.oe[i] : gpio_oe_q[i];
					pad_d.pu[i] = fn[i] == FN_PERIPH ? periph_i.pu[i] : pcr_q[i];
					din_d[i] = pad_in_i[i];
				end
				controlled_nopull_status:
				begin
					pad_d.out[i] = gpio_out_q[i];
					pad_d.oe[i] = gpio_oe_q[i];
					din_d[i] = pad_in_i[i];
				end
				hold_input_status:
				begin
					pad_d.out[i] = hold_src.out[i];
					pad_d.oe[i] = hold_src.oe[i];
					pad_d.pu[i] = hold_src.pu[i];
					din_d[i] = pad_in_i[i];
				end
				hold_isolated_status:
				begin
					pad_d.out[i] = hold_src.out[i];
					pad_d.oe[i] = hold_src.oe[i];
					pad_d.pu[i] = hold_src.pu[i];
				end
				gpio_snapshot_status:
				begin
					pad_d.out[i] = snap_src.out[i];
					pad_d.oe[i] = snap_src.oe[i];
					pad_d.pu[i] = snap_src.pu[i];
				end
				rst_in_status:
				begin
					pad_d.pu[i] = 1'b1;
					din_d[i] = pad_in_i[i];
				end
				boot_in_status: din_d[i] = pad_in_i[i];
				default: din_d[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pad_q <= '0;
			din_q <= '0;
			osc_en_q <= '0;
			usb_q <= '0;
		end
		else
		begin
			pad_q <= pad_d;
			din_q <= din_d;
			osc_en_q <= osc_en_d;
			usb_q <= usb_d;
		end
	end

	assign pad_o = pad_q;
	assign din_o = din_q;
	assign osc_en_o = osc_en_q;
	assign usb_own_o = usb_q;

	// ========================================
	// checks on pin 0, the status column and the bus handshake
	a_iso_pad: assert property (
		stat[0] == isolated_status |=> !pad_q.oe[0] && !pad_q.pu[0] && !din_q[0])
		else $error("isolated pin not hi-z or input not 0");
	a_open_input: assert property (
		stat[0] == input_open_status |=> !pad_q.oe[0] && din_q[0] == $past(pad_in_i[0]))
		else $error("open input not passed");
	a_pull_follow: assert property (
		stat[0] == input_pull_status |=> pad_q.pu[0] == $past(pcr_q[0]) && !pad_q.oe[0])
		else $error("pull does not follow register");
	a_osc_gate: assert property (
		stat[0] == osc_gated_input_status && !osc_running_i[0] |=> !din_q[0])
		else $error("clock input not gated");
	a_usb_own: assert property (
		fn[0] == FN_USB && col == COL_RUN |=> usb_q[0] && !din_q[0] && !pad_q.oe[0])
		else $error("usb pad not owned in run");
	a_reg_drive: assert property (
		stat[0] == reg_controlled_status && fn[0] == FN_GPIO
		|=> pad_q.oe[0] == $past(gpio_oe_q[0]) && pad_q.out[0] == $past(gpio_out_q[0]))
		else $error("gpio drive not applied");
	a_hold_keep: assert property (
		stat[0] == hold_input_status && entry ##1 stat[0] == hold_input_status
		|=> pad_q.out[0] == $past(pad_q.out[0], 2))
		else $error("held output changed");
	a_snap_gate: assert property (
		stat[0] == gpio_snapshot_status |=> !din_q[0] && pad_q.oe[0] == $past(snap_src.oe[0]))
		else $error("snapshot not applied");
	a_dbg_pull: assert property (
		cpu_state_i == CPU_INIT && fn[0] == FN_DBGWIRE |=> pcr_q[0] ##1 pad_q.pu[0])
		else $error("debug wire pull not set");
	a_rst_pin: assert property (
		fn[0] == FN_RSTIN |=> pad_q.pu[0] && !pad_q.oe[0] && din_q[0] == $past(pad_in_i[0]))
		else $error("reset pin not pulled input");
	a_ret_col: assert property (
		$past(cpu_state_i) == CPU_DEEP && cpu_state_i == CPU_RUN && ctrl_q[CTRL_HOLD_BIT]
		|-> col == COL_DS_RET)
		else $error("return column lost");
	a_bus_wait: assert property (
		req && !ack_q |=> !avs_waitrequest_o)
		else $error("bus answer late");
endmodule : psm_pin_ctrl

//--- test/psm_seq_model.sv
// power sequencer model: presents the cpu state to the pin controller
// assumes the bench requests a state just after a clock edge
`timescale 1ns/1ps
module psm_seq_model
	import psm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire psm_cpu_e req_i,
	output psm_cpu_e cpu_state_o
);
	// ==========================================
	// state register
	// power-on versus init
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			cpu_state_o <= CPU_POR;
		else
			cpu_state_o <= req_i;
	end
endmodule : psm_seq_model

//--- test/psm_pin_ctrl_tb.sv
// bench for the pin state controller: bus tasks, reference model, scenarios
// assumes the sequencer model and the controller share one 125 MHz clock
`timescale 1ns/1ps
module psm_pin_ctrl_tb
	import psm_pkg::*;
;
	// ==========================================
	// signals and model state
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	psm_cpu_e req = CPU_POR;
	psm_cpu_e cpu_state;
	logic [3:0] osc = 4'h0;
	logic [3:0] pin = 4'h0;
	psm_pad_s per = '0;
	psm_pad_s pad_o;
	logic [3:0] din_o, osc_en_o, usb_own_o;
	logic [31:0] seed = 32'h41D0C66C;
	logic [31:0] ctrl = 0, func = 0, gpio = 0, pull = 0, q;
	logic [3:0] e_out, e_oe, e_pu, e_din, e_osc, e_usb;
	psm_pad_s hold = '0, snap = '0;
	psm_cpu_e cst = CPU_POR;
	psm_fn_e fn = FN_GPIO;
	psm_fn_e fl[10] = '{FN_GPIO_NP, FN_OSC, FN_CLKIN, FN_ANALOG, FN_USB,
		FN_EXTINT, FN_PERIPH, FN_RSTIN, FN_BOOTIN, FN_GPIO};
	psm_fn_e f2[5] = '{FN_PERIPH, FN_EXTINT, FN_USB, FN_RSTIN, FN_BOOTIN};
	logic ret = 1'b0;
	int col;
	int bad_count = 0;
	int check_count = 0;

	always #4 clk_i = ~clk_i;

	psm_seq_model seq (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .cpu_state_o(cpu_state));

	psm_pin_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .cpu_state_i(cpu_state), .osc_running_i(osc),
		.pad_in_i(pin), .periph_i(per), .pad_o(pad_o), .din_o(din_o), .osc_en_o(osc_en_o),
		.usb_own_o(usb_own_o));

	// ==========================================
	// helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				o[b*8 +: 8] = d[b*8 +: 8];
		end
		return o;
	endfunction : mrg

	task print_verdict();
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		avs_read_i <= !w;
		avs_write_i <= w;
		do
		begin
			@(posedge clk_i);
		end
		while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		bus(1'b1, a, d, be);
		case (a)
			ADDR_CTRL: ctrl = mrg(ctrl, d, be) & 32'h3;
			ADDR_FUNC: func = mrg(func, d, be) & 32'hFFFF;
			ADDR_GPIO: gpio = mrg(gpio, d, be) & 32'h0F0F;
			ADDR_PULL: pull = mrg(pull, d, be) & 32'hF;
			default: ;
		endcase
		fn = psm_fn_e'(func[3:0]);
		if (!ctrl[1])
			ret = 1'b0;
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		cmp("register", e, q);
	endtask : rdc

	task rnd();
		logic [31:0] r;
		r = xs();
		@(posedge clk_i);
		per <= r[11:0];
		pin <= r[15:12];
		osc <= r[19:16];
	endtask : rnd

	// ==========================================
	// reference model of the pad controls
	task model();
		if (fn == FN_DBGWIRE && cst == CPU_INIT)
			pull = 32'hF;
		case (cst)
			CPU_POR: col = 0;
			CPU_INIT: col = 1;
			CPU_RUN: col = (ret && ctrl[1]) ? 7 : 2;
			CPU_STBY: col = ctrl[0] ? 4 : 3;
			default: col = ctrl[0] ? 6 : 5;
		endcase
		{e_out, e_oe, e_pu, e_din, e_osc, e_usb} = '0;
		if (fn == FN_RSTIN)
			{e_pu, e_din} = {4'hF, pin};
		else if (fn == FN_BOOTIN)
			e_din = pin;
		else if (col == 2)
		begin
			case (fn)
				FN_GPIO: {e_out, e_oe, e_pu, e_din} = {gpio[3:0], gpio[11:8], pull[3:0], pin};
				FN_GPIO_NP: {e_out, e_oe, e_din} = {gpio[3:0], gpio[11:8], pin};
				FN_OSC: e_osc = 4'hF;
				FN_CLKIN: e_din = pin & osc;
				FN_USB: e_usb = 4'hF;
				FN_EXTINT: {e_pu, e_din} = {pull[3:0], pin};
				FN_PERIPH: {e_out, e_oe, e_pu, e_din} = {per, pin};
				default: ;
			endcase
		end
		else if (fn == FN_EXTINT && (col == 3 || col == 4))
			{e_pu, e_din} = {pull[3:0], pin};
		else if (fn == FN_PERIPH && col == 3)
			{e_out, e_oe, e_pu, e_din} = {hold, pin};
		else if ((fn == FN_PERIPH || fn == FN_EXTINT) && (col == 5 || col == 7))
			{e_out, e_oe, e_pu} = snap;
		else if (fn == FN_DBGWIRE && col == 1)
			{e_pu, e_din} = {4'hF, pin};
	endtask : model

	task go(input psm_cpu_e st);
		@(posedge clk_i);
		model();
		if ((st == CPU_STBY || st == CPU_DEEP) && !(cst inside {CPU_STBY, CPU_DEEP}))
		begin
			hold = {e_out, e_oe, e_pu};
			snap = {gpio[3:0], gpio[11:8], pull[3:0]};
		end
		if (st == CPU_DEEP)
			ret = 1'b1;
		else if (st != CPU_RUN || !ctrl[1])
			ret = 1'b0;
		cst = st;
		req <= st;
	endtask : go

	task chk();
		logic [31:0] s;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		model();
		cmp("pad_out", e_out, pad_o.out);
		cmp("pad_oe", e_oe, pad_o.oe);
		cmp("pad_pu", e_pu, pad_o.pu);
		cmp("din", e_din, din_o);
		cmp("osc_en", e_osc, osc_en_o);
		cmp("usb_own", e_usb, usb_own_o);
		s = '0;
		s[3:0] = e_oe;
		s[7:4] = e_pu;
		s[11:8] = e_din;
		s[18:16] = col[2:0];
		s[20] = ret;
		bus(1'b0, ADDR_STAT, 32'h0, 4'hF);
		cmp("status", s, q);
	endtask : chk

	// ==========================================
	// scenarios
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rdc(ADDR_CTRL, 32'h0);
		rdc(ADDR_FUNC, 32'h0);
		rdc(ADDR_GPIO, 32'h0);
		rdc(ADDR_PULL, 32'h0);
		wr(8'h14, 32'hFFFFFFFF, 4'hF);
		wr(ADDR_STAT, 32'hFFFFFFFF, 4'hF);
		rdc(8'h14, 32'h0);
		rnd();
		chk();
		wr(ADDR_FUNC, 32'h8888, 4'hF);
		chk();
		go(CPU_INIT);
		chk();
		rdc(ADDR_PULL, pull);
		go(CPU_RUN);
		foreach (fl[i])
		begin
			wr(ADDR_FUNC, {16'h0, {4{fl[i][3:0]}}}, 4'hF);
			wr(ADDR_GPIO, xs() & 32'h0F0F, 4'hF);
			wr(ADDR_PULL, xs() & 32'hF, 4'hF);
			rnd();
			chk();
		end
		wr(ADDR_GPIO, xs() & 32'h0F0F, 4'h2);
		rdc(ADDR_GPIO, gpio);
		chk();
		foreach (f2[i])
		begin
			for (int s = 0; s < 2; s++)
			begin
				for (int l = 0; l < 2; l++)
				begin
					wr(ADDR_FUNC, {16'h0, {4{f2[i][3:0]}}}, 4'hF);
					wr(ADDR_CTRL, {30'h0, 1'b1, l[0]}, 4'hF);
					wr(ADDR_GPIO, xs() & 32'h0F0F, 4'hF);
					wr(ADDR_PULL, xs() & 32'hF, 4'hF);
					rnd();
					chk();
					go(s ? CPU_DEEP : CPU_STBY);
					chk();
					rnd();
					wr(ADDR_GPIO, xs() & 32'h0F0F, 4'hF);
					chk();
					go(CPU_RUN);
					chk();
					wr(ADDR_CTRL, 32'h0, 4'hF);
					chk();
				end
			end
		end
		print_verdict();
	end

	initial
	begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		print_verdict();
	end
endmodule : psm_pin_ctrl_tb
